// file: logic/timer_pkg.sv
// Constants and register layout for the prescaled down-counter timer
package timer_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_COUNT = 12'h000;
	localparam logic [11:0] OFS_CTRL = 12'h004;
	localparam logic [11:0] OFS_OPTION = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_FLAG = 7;
	localparam int CTRL_MASK = 6;
	localparam int CTRL_EXT = 5;
	localparam int CTRL_GATE = 4;
	localparam int CTRL_PSC = 3;
	localparam int OPT_SOURCE = 6;
	localparam int STAT_REQ = 0;
	localparam int STAT_CPU = 1;
	// ------------------------------------------------------------
	// Widths, reset values, constants
	// ------------------------------------------------------------
	localparam int CNT_W = 8;
	localparam int PRE_W = 7;
	localparam int SEL_W = 3;
	localparam logic [7:0] COUNT_RESET = 8'hFF;
	localparam logic [6:0] PRE_RESET = 7'h7F;
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [5:0] LOW_ONES = 6'h3F;
	localparam logic [10:0] TIMER_VECTOR = 11'h7F8;
	// Register index decode results
	typedef enum logic [4:0] {
		IDX_COUNT = 5'b00001,
		IDX_CTRL = 5'b00010,
		IDX_OPTION = 5'b00100,
		IDX_STATUS = 5'b01000,
		IDX_NONE = 5'b10000
	} reg_idx_type;
endpackage : timer_pkg

// file: logic/presc_bus_if.sv
// Bundle between the timer core and its prescaler
`timescale 1ns/1ns
interface presc_bus_if;
	import timer_pkg::*;
	logic tick_in;
	logic clear;
	logic [SEL_W-1:0] sel;
	logic tick_out;
	modport core (output tick_in, output clear, output sel, input tick_out);
	modport presc (input tick_in, input clear, input sel, output tick_out);
endinterface : presc_bus_if

// file: logic/timer_prescaler.sv
// Seven-bit binary prescaler with selectable tap
`timescale 1ns/1ns
module timer_prescaler
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Core side
	presc_bus_if.presc pb
);
	typedef struct packed {
		logic [PRE_W-1:0] cnt;
	} pre_state_type;

	pre_state_type st_r;
	pre_state_type st_nxt;
	logic [PRE_W:0] ones_below;

	// ------------------------------------------------------------
	// Carry chain: tap k fires when the low k bits are all ones
	// ------------------------------------------------------------
	assign ones_below[0] = 1'b1;
	genvar k;
	generate
		for (k = 0; k < PRE_W; k++) begin : g_chain
			assign ones_below[k+1] = ones_below[k] & st_r.cnt[k];
		end
	endgenerate

	assign pb.tick_out = pb.tick_in & ones_below[pb.sel];

	// Next state: clear wins over counting to avoid truncation
	always_comb begin
		st_nxt = st_r;
		if (pb.clear) begin
			st_nxt.cnt = PRE_RESET;
		end else if (pb.tick_in) begin
			st_nxt.cnt = st_r.cnt + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.cnt <= PRE_RESET;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// a written clear bit restarts the divider from all ones
	chk_clear_ones: assert property (@(posedge pclk) disable iff (!presetn)
		ce && pb.clear |=> st_r.cnt == PRE_RESET)
		else $error("prescaler clear missed");
endmodule : timer_prescaler

// file: logic/timer_top.sv
// Prescaled eight-bit down-counter timer with APB registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module timer_top
	import timer_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External count pin
	input wire logic timer_pin,
	// CPU side
	input wire logic cpu_i_mask,
	output logic timer_irq,
	output logic cpu_irq,
	output logic [10:0] irq_vector
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic flag;
		logic mask;
		logic ext;
		logic gate;
		logic [SEL_W-1:0] sel;
		logic [7:0] option;
		logic pin_d;
		logic irq;
		logic cpu;
		logic [10:0] vec;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} top_state_type;

	top_state_type st_r;
	top_state_type st_nxt;
	presc_bus_if pb ();

	// Address decode used for both reads and writes
	function automatic reg_idx_type decode(input logic [11:0] a);
		case (a)
			OFS_COUNT: decode = IDX_COUNT;
			OFS_CTRL: decode = IDX_CTRL;
			OFS_OPTION: decode = IDX_OPTION;
			OFS_STATUS: decode = IDX_STATUS;
			default: decode = IDX_NONE;
		endcase
	endfunction : decode

	// ------------------------------------------------------------
	// Effective source selection
	// ------------------------------------------------------------
	logic opt_mode;
	logic eff_gate;
	logic eff_ext;
	logic [SEL_W-1:0] eff_sel;
	logic pin_rise;
	logic src_tick;
	logic setup_rd;
	logic wr_now;
	reg_idx_type setup_idx;
	reg_idx_type acc_idx;
	logic [7:0] ctrl_view;

	// option byte or control register drives the source
	assign opt_mode = st_r.option[OPT_SOURCE];
	assign eff_gate = opt_mode ? 1'b1 : st_r.gate;
	assign eff_ext = opt_mode ? st_r.option[CTRL_EXT] : st_r.ext;
	assign eff_sel = opt_mode ? st_r.option[SEL_W-1:0] : st_r.sel;
	// Pin idles low, so the cleared sample after reset gives no false edge
	// pin edge seen against last cycle's sample
	assign pin_rise = timer_pin & ~st_r.pin_d;

	// source mux ahead of the prescaler
	always_comb begin
		case ({eff_ext, eff_gate})
			2'b00: src_tick = 1'b1;
			2'b01: src_tick = timer_pin;
			2'b10: src_tick = 1'b0;
			2'b11: src_tick = pin_rise;
			default: src_tick = 1'b0;
		endcase
	end

	assign setup_idx = decode(paddr);
	assign acc_idx = decode(paddr);
	assign setup_rd = psel & ~penable & ~pwrite;
	// Writes land at the access edge, pready is high from the first enabled edge after reset
	assign wr_now = psel & penable & pwrite & st_r.ready;

	// low six bits read ones in option mode
	assign ctrl_view = opt_mode ? {st_r.flag, st_r.mask, LOW_ONES}
		: {st_r.flag, st_r.mask, st_r.ext, st_r.gate, 1'b0, st_r.sel};

	// ------------------------------------------------------------
	// Prescaler hookup
	// ------------------------------------------------------------
	// clear on a one written to bit 3, software mode only
	assign pb.clear = wr_now & (acc_idx == IDX_CTRL) & ~opt_mode & pwdata[CTRL_PSC];
	// Clear eats this cycle's input tick so divided counting starts clean
	// source feeds the prescaler, its tap feeds the counter
	assign pb.tick_in = src_tick & ~pb.clear;
	assign pb.sel = eff_sel;

	timer_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pb(pb)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_d = timer_pin;
		// zero falls through to all ones
		if (pb.tick_out) begin
			st_nxt.count = st_r.count - 8'h01;
		end
		// Software load overrides a same-cycle decrement
		if (wr_now && acc_idx == IDX_COUNT) begin
			st_nxt.count = pwdata[CNT_W-1:0];
		end
		// Control write; low bits ignored in option mode
		if (wr_now && acc_idx == IDX_CTRL) begin
			st_nxt.flag = st_r.flag & pwdata[CTRL_FLAG];
			st_nxt.mask = pwdata[CTRL_MASK];
			if (!opt_mode) begin
				st_nxt.ext = pwdata[CTRL_EXT];
				st_nxt.gate = pwdata[CTRL_GATE];
				st_nxt.sel = pwdata[SEL_W-1:0];
			end
		end
		if (wr_now && acc_idx == IDX_OPTION) begin
			st_nxt.option = pwdata[7:0];
		end
		// reaching zero sets the flag; set wins over a clear
		if (pb.tick_out && st_r.count == 8'h01) begin
			st_nxt.flag = 1'b1;
		end
		// request is flag and not mask, every cycle
		// a level, so a masked clear never pulses it
		st_nxt.irq = st_nxt.flag & ~st_nxt.mask;
		// held while the CPU mask is set
		// unmasked request goes to the CPU with its vector
		st_nxt.cpu = st_nxt.irq & ~cpu_i_mask;
		st_nxt.vec = TIMER_VECTOR;
		// reads only copy state into the data register
		st_nxt.ready = 1'b1;
		if (psel && !penable) begin
			st_nxt.err = (setup_idx == IDX_NONE);
			st_nxt.rdata = 32'h0000_0000;
			if (setup_rd) begin
				case (setup_idx)
					IDX_COUNT: st_nxt.rdata = {24'h00_0000, st_r.count};
					IDX_CTRL: st_nxt.rdata = {24'h00_0000, ctrl_view};
					IDX_OPTION: st_nxt.rdata = {24'h00_0000, st_r.option};
					IDX_STATUS: st_nxt.rdata = {30'h0000_0000, st_r.cpu, st_r.irq};
					default: st_nxt.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// reset to all ones, flag clear, mask set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.count <= COUNT_RESET;
			st_r.flag <= 1'b0;
			st_r.mask <= 1'b1;
			st_r.ext <= OPTION_RESET[CTRL_EXT];
			st_r.gate <= OPTION_RESET[CTRL_GATE];
			st_r.sel <= OPTION_RESET[SEL_W-1:0];
			st_r.option <= OPTION_RESET;
			st_r.pin_d <= 1'b0;
			st_r.irq <= 1'b0;
			st_r.cpu <= 1'b0;
			st_r.vec <= TIMER_VECTOR;
			st_r.rdata <= 32'h0000_0000;
			st_r.ready <= 1'b0;
			st_r.err <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs, straight from flops
	// ------------------------------------------------------------
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.err;
	assign timer_irq = st_r.irq;
	assign cpu_irq = st_r.cpu;
	assign irq_vector = st_r.vec;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_tick_at_one;
		ce && pb.tick_out && st_r.count == 8'h01 && !(wr_now && acc_idx == IDX_COUNT);
	endsequence

	sequence s_disabled_quiet;
		ce && !opt_mode && st_r.ext && !st_r.gate && !wr_now;
	endsequence

	sequence s_count_write;
		ce && wr_now && acc_idx == IDX_COUNT;
	endsequence

	sequence s_plain_tick;
		ce && pb.tick_out && !(wr_now && acc_idx == IDX_COUNT);
	endsequence

	sequence s_gate_closed;
		ce && !opt_mode && st_r.gate && !st_r.ext && !timer_pin && !wr_now;
	endsequence

	sequence s_flag_cleared;
		ce && wr_now && acc_idx == IDX_CTRL && !pwdata[CTRL_FLAG]
			&& !(pb.tick_out && st_r.count == 8'h01);
	endsequence

	// flag follows the step from one to zero
	chk_flag_on_zero: assert property (s_tick_at_one |=> st_r.flag && st_r.count == 8'h00)
		else $error("flag not set on zero");
	// zero falls through to all ones
	chk_wrap_to_ones: assert property (ce && pb.tick_out && st_r.count == 8'h00
		&& !wr_now |=> st_r.count == 8'hFF)
		else $error("counter did not wrap");
	// request level tracks flag and mask
	chk_irq_level: assert property (timer_irq == (st_r.flag && !st_r.mask))
		else $error("request not flag and not mask");
	// a set mask keeps the request low
	chk_mask_blocks: assert property (st_r.mask |-> !timer_irq)
		else $error("masked request reached output");
	// CPU mask holds the request back
	chk_cpu_pending: assert property (ce && cpu_i_mask |=> !cpu_irq)
		else $error("request passed CPU mask");
	// a read alone leaves the count alone
	chk_read_pure: assert property (ce && setup_rd && !pb.tick_out && !wr_now
		|=> $stable(st_r.count))
		else $error("read disturbed count");
	chk_disabled_src: assert property (s_disabled_quiet ##1 s_disabled_quiet
		|=> $stable(st_r.count))
		else $error("disabled source still counted");
	// clear bit reads back as zero in software mode
	chk_psc_reads_zero: assert property (ce && setup_rd && !opt_mode
		&& setup_idx == IDX_CTRL |=> prdata[CTRL_PSC] == 1'b0)
		else $error("bit 3 read nonzero");
	// option mode shows ones below the mask
	chk_opt_ones: assert property (ce && setup_rd && opt_mode
		&& setup_idx == IDX_CTRL |=> prdata[5:0] == LOW_ONES)
		else $error("option mode bits not ones");

	// ------------------------------------------------------------
	// Loads, stepping, gating and the CPU path
	// ------------------------------------------------------------
	// software load lands at the access edge
	chk_count_load: assert property (s_count_write |=> st_r.count == $past(pwdata[7:0]))
		else $error("count load lost");
	// each prescaler output takes one off
	chk_one_step: assert property (s_plain_tick |=> st_r.count == $past(st_r.count) - 8'h01)
		else $error("count did not step by one");
	chk_gate_holds: assert property (s_gate_closed |=> $stable(st_r.count))
		else $error("closed gate still counted");
	// a written zero clears the flag
	chk_flag_clear: assert property (s_flag_cleared |=> !st_r.flag)
		else $error("flag clear ignored");
	// open request reaches the CPU next edge
	chk_cpu_passes: assert property (ce && st_r.flag && !st_r.mask
		&& !cpu_i_mask && !wr_now |=> cpu_irq)
		else $error("open request did not reach CPU");
	chk_vector_fixed: assert property (irq_vector == TIMER_VECTOR)
		else $error("vector changed");
	// control writes leave source bits in option mode
	chk_opt_locked: assert property (ce && wr_now && opt_mode
		|=> $stable(st_r.sel) && $stable(st_r.ext) && $stable(st_r.gate))
		else $error("option mode source bits written");
	// both source bits clear feed every cycle
	chk_tick_internal: assert property (ce && !eff_ext && !eff_gate && !pb.clear
		|-> pb.tick_in)
		else $error("internal clock tick missing");
endmodule : timer_top

// file: sim/cpu_model.sv
// Behavioural CPU core that takes the timer interrupt
`timescale 1ns/1ns
module cpu_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Timer side
	input wire logic timer_irq,
	input wire logic cpu_irq,
	input wire logic [10:0] irq_vector,
	// Bench control and observation
	input wire logic hold_i,
	output logic cpu_i_mask,
	output logic [7:0] taken_cnt,
	output logic [10:0] fetch_addr
);
	logic in_service_r;
	// I bit held by bench or by entry
	assign cpu_i_mask = hold_i | in_service_r;
	// Enter on level, leave once flag cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_service_r <= 1'b0;
			taken_cnt <= 8'h00;
			fetch_addr <= 11'h000;
		end else if (cpu_irq && !cpu_i_mask) begin
			in_service_r <= 1'b1;
			taken_cnt <= taken_cnt + 8'h01;
			fetch_addr <= irq_vector;
		end else if (in_service_r && !timer_irq) begin
			in_service_r <= 1'b0;
		end
	end
endmodule : cpu_model

// file: sim/prescaled_down_counter_timer_tb_top.sv
// Self-checking bench for the prescaled down-counter timer
`timescale 1ns/1ns
module prescaled_down_counter_timer_tb_top;
	import timer_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic timer_pin = 1'b0;
	logic hold_i = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, timer_irq, cpu_irq, cpu_i_mask;
	logic [10:0] irq_vector, fetch_addr;
	logic [7:0] taken_cnt;
	logic [32:0] exp_q[$];
	logic [31:0] seed = 32'h4FB95BC1;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	always #50 pclk = ~pclk;
	timer_top timer_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin(timer_pin),
		.cpu_i_mask(cpu_i_mask), .timer_irq(timer_irq), .cpu_irq(cpu_irq),
		.irq_vector(irq_vector));
	cpu_model cpu_model_i (.pclk(pclk), .presetn(presetn), .timer_irq(timer_irq),
		.cpu_irq(cpu_irq), .irq_vector(irq_vector), .hold_i(hold_i),
		.cpu_i_mask(cpu_i_mask), .taken_cnt(taken_cnt), .fetch_addr(fetch_addr));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic check_rd(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_rd
	task automatic check_lvl(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_lvl
	// Entered just after an edge; one idle cycle keeps drives single per step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd
	// Each pulse is one rising edge seen by the pin logic
	task automatic pulses(input int n);
		repeat (n) begin
			timer_pin <= 1'b1;
			@(posedge pclk);
			timer_pin <= 1'b0;
			@(posedge pclk);
		end
	endtask : pulses
	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	// Read data taken at the sampling edge of the access phase
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			check_rd({pslverr, prdata}, exp_q.pop_front());
		end
	end
	// Whole run needs about 1300 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check_lvl(32'({timer_irq, cpu_irq, irq_vector}), 32'h7F8);
		rd(OFS_CTRL, 32'h40);
		apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
		// Disabled source ignores pin edges
		seed = xorshift(seed);
		wr(OFS_CTRL, 32'h60);
		wr(OFS_COUNT, {24'h0, seed[7:0]});
		pulses(3);
		rd(OFS_COUNT, {24'h0, seed[7:0]});
		rd(OFS_COUNT, {24'h0, seed[7:0]});
		// Pin edges through every divide, with prescaler clear each time
		for (int s = 0; s < 8; s++) begin
			wr(OFS_CTRL, 32'h38 | s);
			wr(OFS_COUNT, 32'h2);
			pulses(1 + (1 << s));
			rd(OFS_COUNT, 32'h0);
			rd(OFS_CTRL, 32'hB0 | s);
			check_lvl(32'({timer_irq, cpu_irq}), 32'h2);
			pulses(1 << s);
			rd(OFS_COUNT, 32'hFF);
			wr(OFS_CTRL, 32'h70 | s);
			rd(OFS_STATUS, 32'h0);
		end
		check_lvl(32'(taken_cnt), 32'h0);
		// Gated clock, request held pending by the CPU mask
		wr(OFS_CTRL, 32'h18);
		wr(OFS_COUNT, 32'h3);
		rd(OFS_COUNT, 32'h3);
		timer_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		timer_pin <= 1'b0;
		rd(OFS_COUNT, 32'h0);
		check_lvl(32'({timer_irq, cpu_irq, taken_cnt}), 32'h200);
		hold_i <= 1'b0;
		repeat (3) @(posedge pclk);
		check_lvl(32'({taken_cnt, fetch_addr}), 32'({8'h1, 11'h7F8}));
		// Service routine clears the flag
		wr(OFS_CTRL, 32'h10);
		repeat (2) @(posedge pclk);
		check_lvl(32'({timer_irq, cpu_irq, taken_cnt}), 32'h001);
		// Option byte takes over the low control bits
		wr(OFS_OPTION, 32'h40);
		wr(OFS_CTRL, 32'h40);
		rd(OFS_CTRL, 32'h7F);
		// Option byte selects a gated internal clock
		wr(OFS_COUNT, 32'h5);
		timer_pin <= 1'b1;
		repeat (2) @(posedge pclk);
		timer_pin <= 1'b0;
		rd(OFS_COUNT, 32'h3);
		// Clock enable low freezes the count with the gate open
		ce <= 1'b0;
		timer_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		timer_pin <= 1'b0;
		rd(OFS_COUNT, 32'h3);
		// Second reset restores the software-controlled defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_OPTION, 32'h0);
		rd(OFS_CTRL, 32'h40);
		tally_and_finish();
	end
endmodule : prescaled_down_counter_timer_tb_top
